//--- pkg/pattern_pulse_unit_cfg.svh
// constants of the pattern pulse unit: register indices, reset values, timing
// assumes inclusion by name from package and design files alike
`ifndef PATTERN_PULSE_UNIT_CFG_SVH
`define PATTERN_PULSE_UNIT_CFG_SVH

// bus geometry: byte address is four times the register index
`define PPU_ADDR_W 18
`define PPU_DATA_W 32
`define PPU_IDX_LSB 2

// register indices as printed
`define IDX_OUTPUT_MODE_CONFIG 16'hffa0
`define IDX_TRIGGER_SELECT_CONTROL 16'hffa1
`define IDX_NEXT_ENABLE_HIGH 16'hffa2
`define IDX_NEXT_ENABLE_LOW 16'hffa3
`define IDX_NEXT_PATTERN_HIGH 16'hffa4
`define IDX_NEXT_PATTERN_LOW 16'hffa5
`define IDX_NEXT_PATTERN_HIGH_ALT 16'hffa6
`define IDX_NEXT_PATTERN_LOW_ALT 16'hffa7
`define IDX_PORT_A_DIRECTION 16'hffd1
`define IDX_PORT_A_OUTPUT_VALUE 16'hffd3
`define IDX_PORT_B_DIRECTION 16'hffd4
`define IDX_PORT_B_OUTPUT_VALUE 16'hffd6

// reset values
`define RST_OUTPUT_MODE_CONFIG 8'hf0
`define RST_TRIGGER_SELECT_CONTROL 8'hff
`define RST_NEXT_ENABLE 8'h00
`define RST_NEXT_PATTERN 8'h00
`define RST_PORT_DIRECTION 8'h00
`define RST_PORT_OUTPUT_VALUE 8'h00

// field layout
`define MODE_NONOVL_LSB 0
`define MODE_RSVD_VAL 4'hf
`define TRIG_SEL_W 2
`define NIBBLE_LOW 8'h0f
`define NIBBLE_HIGH 8'hf0
`define MISSING_BIT_POS 14
`define WO_READ_VAL 8'hff

// timing: non-overlap margin, least time rounded up to whole cycles
`define CLK_PERIOD_NS 10
`define NONOVL_MARGIN_NS 40
`define NONOVL_CYC ((`NONOVL_MARGIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- pkg/pattern_pulse_pkg.sv
// types shared by the pattern pulse unit and its surroundings
// assumes the constants header is on the include path
`include "pattern_pulse_unit_cfg.svh"

package pattern_pulse_pkg;

	// one avalon-mm request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [`PPU_ADDR_W-1:0] address;
		logic [`PPU_DATA_W-1:0] writedata;
		logic [3:0] byteenable;
	} avl_req_t;

	// answer towards the master
	typedef struct packed {
		logic [`PPU_DATA_W-1:0] readdata;
		logic waitrequest;
	} avl_rsp_t;

	// pin bundle: value and enable per pattern bit
	typedef struct packed {
		logic [15:0] value;
		logic [15:0] enable;
	} pattern_pins_t;

	// avalon slave handshake phase
	typedef enum logic {
		BUS_WAIT = 1'b0,
		BUS_ACK = 1'b1
	} bus_phase_t;

endpackage : pattern_pulse_pkg

//--- src/timing_pattern_output.sv
// pattern pulse unit: fifteen pattern pins in four groups, avalon-mm registers
// assumes one clock, compare-match inputs are one-cycle pulses on clk_i
`include "pattern_pulse_unit_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module timing_pattern_output #(
	parameter int unsigned GROUPS = 4,
	parameter int unsigned CHANNELS = 4,
	parameter int unsigned MARGIN_CYC = `NONOVL_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// avalon-mm slave
	input wire pattern_pulse_pkg::avl_req_t avl_req_i,
	output pattern_pulse_pkg::avl_rsp_t avl_rsp_o,
	// timer compare-match pulses, one per channel
	input wire logic [CHANNELS-1:0] compare_match_i,
	// pattern pins
	output pattern_pulse_pkg::pattern_pins_t pattern_out_bit_o
);
	import pattern_pulse_pkg::*;

	// register map, by index (byte address is four times the index)
	//   ffa0 output mode: low nibble non-overlap per group, high nibble reads ones
	//   ffa1 trigger select: two bits per group, group 0 in bits 1..0
	//   ffa2 next enable, bits 15..8 of the pattern
	//   ffa3 next enable, bits 7..0 of the pattern
	//   ffa4 next pattern high: whole byte on a shared trigger, group 3 otherwise
	//   ffa5 next pattern low: whole byte on a shared trigger, group 1 otherwise
	//   ffa6 next pattern high, group 2 nibble, only while triggers differ
	//   ffa7 next pattern low, group 0 nibble, only while triggers differ
	//   ffd1 port a direction, write-only, reads as all ones
	//   ffd3 port a data, pattern bits 7..0
	//   ffd4 port b direction, write-only, reads as all ones
	//   ffd6 port b data, pattern bits 15..8
	//
	// bus timing
	//   a request is seen at one edge while waitrequest is high
	//   waitrequest then drops for exactly one cycle
	//   the write lands at the edge that ends that cycle
	//   read data is latched when the request is first seen
	//   so a read costs one wait cycle and one acknowledge cycle
	//   back-to-back requests are fine; each takes two cycles
	//   only byte lane 0 carries register data; upper lanes read zero
	//   a write with byte lane 0 disabled is dropped
	//   unmapped indices ignore writes and read as zero
	//
	// trigger timing
	//   a compare-match pulse is taken at the edge where it is high
	//   the data register updates at that edge
	//   the pins follow one edge later, from the pin stage flops
	//   several groups may update at the same edge, each on its nibble
	//   a group ignores pulses of channels it has not selected
	//   bits whose next-enable is clear keep their value on a trigger
	//
	// non-overlap
	//   at the trigger only falling changes are applied
	//   rising changes wait for the margin counter to run out
	//   a fresh trigger restarts the margin and drops the pending rise
	//   limitation: a rise pending when non-overlap is switched off
	//   still lands when its counter expires
	//
	// port data registers
	//   a bus write only reaches bits whose next-enable is clear
	//   a trigger wins over a bus write on enabled bits at one edge
	//   bits read back the value held, whether driven or not
	//
	// pins
	//   direction bits gate the pin enables one cycle late, like values
	//   bit 14 has no pin: value and enable stay low for good
	//   the pin stage costs a cycle but keeps every output on a flop
	//
	// hazards
	//   changing the trigger select while a channel pulses may move
	//   the next-pattern address split in the same cycle as a trigger;
	//   software should set triggers before loading next patterns
	//   the split is decided from the live select bits, not a copy,
	//   so a readback always matches the current addressing
	//
	// widths
	//   the margin counter is sized from the margin parameter
	//   a margin of one still needs one flop for the counter
	//   the register index drops the two byte-offset bits
	//
	// trade-offs
	//   one wait cycle per access keeps the read path fully registered
	//   next-pattern nibbles are masked rather than stored twice
	//   the read mux is flat, one case item per index
	//   the pin stage duplicates the data register for clean outputs
	//
	localparam int unsigned CW = (MARGIN_CYC < 2) ? 1 : $clog2(MARGIN_CYC + 1);
	localparam int unsigned IW = `PPU_ADDR_W - `PPU_IDX_LSB;

	// register file
	logic [7:0] mode_q;
	logic [7:0] trig_sel_q;
	logic [7:0] next_en_hi_q;
	logic [7:0] next_en_lo_q;
	logic [7:0] next_pat_hi_q;
	logic [7:0] next_pat_lo_q;
	logic [7:0] dir_a_q;
	logic [7:0] dir_b_q;
	logic [15:0] out_data_q;
	logic [15:0] out_data_d;

	// bus handshake
	bus_phase_t phase_q;
	logic wait_q;
	logic [`PPU_DATA_W-1:0] rdata_q;
	logic [7:0] rdata_d;
	logic req;
	logic accept;
	logic wr_en;
	logic [IW-1:0] idx;
	logic [7:0] wbyte;

	// group bookkeeping
	logic same_lo;
	logic same_hi;
	logic [7:0] lo_mask_main;
	logic [7:0] lo_mask_alt;
	logic [7:0] hi_mask_main;
	logic [7:0] hi_mask_alt;
	logic [15:0] next_en;
	logic [15:0] next_pat;
	logic [GROUPS-1:0] grp_trig;
	logic [GROUPS-1:0] grp_upd;
	logic [3:0] grp_val [GROUPS];

	assign req = avl_req_i.read | avl_req_i.write;
	assign accept = req & (phase_q == BUS_ACK);
	assign wr_en = avl_req_i.write & accept & avl_req_i.byteenable[0];
	assign idx = avl_req_i.address[`PPU_ADDR_W-1:`PPU_IDX_LSB];
	assign wbyte = avl_req_i.writedata[7:0];
	assign next_en = {next_en_hi_q, next_en_lo_q};
	assign next_pat = {next_pat_hi_q, next_pat_lo_q};

	// shared trigger decides how the next-pattern registers are addressed
	assign same_lo = (trig_sel_q[3:2] == trig_sel_q[1:0]);
	assign same_hi = (trig_sel_q[7:6] == trig_sel_q[5:4]);
	assign lo_mask_main = same_lo ? 8'hff : `NIBBLE_HIGH;
	assign lo_mask_alt = same_lo ? 8'h00 : `NIBBLE_LOW;
	assign hi_mask_main = same_hi ? 8'hff : `NIBBLE_HIGH;
	assign hi_mask_alt = same_hi ? 8'h00 : `NIBBLE_LOW;

	// waitrequest: low for one cycle after a request is seen, then high again
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_q <= BUS_WAIT;
		end else if (phase_q == BUS_ACK) begin
			phase_q <= BUS_WAIT;
		end else if (req) begin
			phase_q <= BUS_ACK;
		end
	end

	// waitrequest kept in its own flop so the output needs no decode
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
		end else if (phase_q == BUS_ACK) begin
			wait_q <= 1'b1;
		end else if (req) begin
			wait_q <= 1'b0;
		end
	end

	// read mux; unmapped indices and unused nibbles read as ones or zero
	always_comb begin
		rdata_d = 8'h00;
		unique case (idx)
			`IDX_OUTPUT_MODE_CONFIG: rdata_d = mode_q;
			`IDX_TRIGGER_SELECT_CONTROL: rdata_d = trig_sel_q;
			`IDX_NEXT_ENABLE_HIGH: rdata_d = next_en_hi_q;
			`IDX_NEXT_ENABLE_LOW: rdata_d = next_en_lo_q;
			`IDX_NEXT_PATTERN_HIGH: rdata_d = next_pat_hi_q | ~hi_mask_main;
			`IDX_NEXT_PATTERN_LOW: rdata_d = next_pat_lo_q | ~lo_mask_main;
			`IDX_NEXT_PATTERN_HIGH_ALT: rdata_d = same_hi ? 8'h00 : (next_pat_hi_q | `NIBBLE_HIGH);
			`IDX_NEXT_PATTERN_LOW_ALT: rdata_d = same_lo ? 8'h00 : (next_pat_lo_q | `NIBBLE_HIGH);
			`IDX_PORT_A_DIRECTION: rdata_d = `WO_READ_VAL;
			`IDX_PORT_B_DIRECTION: rdata_d = `WO_READ_VAL;
			`IDX_PORT_A_OUTPUT_VALUE: rdata_d = out_data_q[7:0];
			`IDX_PORT_B_OUTPUT_VALUE: rdata_d = out_data_q[15:8];
			default: rdata_d = 8'h00;
		endcase
	end

	// read data captured when the request is first seen, stands while acked
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= '0;
		end else if (req && phase_q == BUS_WAIT) begin
			rdata_q <= {{(`PPU_DATA_W-8){1'b0}}, rdata_d};
		end
	end

	// mode register: upper nibble reserved, reads as ones
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= `RST_OUTPUT_MODE_CONFIG;
		end else if (wr_en && idx == `IDX_OUTPUT_MODE_CONFIG) begin
			mode_q <= {`MODE_RSVD_VAL, wbyte[3:0]};
		end
	end

	// trigger select: two bits per group, group 0 in the low pair
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trig_sel_q <= `RST_TRIGGER_SELECT_CONTROL;
		end else if (wr_en && idx == `IDX_TRIGGER_SELECT_CONTROL) begin
			trig_sel_q <= wbyte;
		end
	end

	// next-enable registers, one bit per pattern bit
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			next_en_hi_q <= `RST_NEXT_ENABLE;
			next_en_lo_q <= `RST_NEXT_ENABLE;
		end else if (wr_en) begin
			if (idx == `IDX_NEXT_ENABLE_HIGH) begin
				next_en_hi_q <= wbyte;
			end
			if (idx == `IDX_NEXT_ENABLE_LOW) begin
				next_en_lo_q <= wbyte;
			end
		end
	end

	// next-pattern registers; each address reaches only its own nibbles
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			next_pat_hi_q <= `RST_NEXT_PATTERN;
			next_pat_lo_q <= `RST_NEXT_PATTERN;
		end else if (wr_en) begin
			if (idx == `IDX_NEXT_PATTERN_HIGH) begin
				next_pat_hi_q <= (next_pat_hi_q & ~hi_mask_main) | (wbyte & hi_mask_main);
			end
			if (idx == `IDX_NEXT_PATTERN_HIGH_ALT) begin
				next_pat_hi_q <= (next_pat_hi_q & ~hi_mask_alt) | (wbyte & hi_mask_alt);
			end
			if (idx == `IDX_NEXT_PATTERN_LOW) begin
				next_pat_lo_q <= (next_pat_lo_q & ~lo_mask_main) | (wbyte & lo_mask_main);
			end
			if (idx == `IDX_NEXT_PATTERN_LOW_ALT) begin
				next_pat_lo_q <= (next_pat_lo_q & ~lo_mask_alt) | (wbyte & lo_mask_alt);
			end
		end
	end

	// port direction: write-only, every pin starts as input
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dir_a_q <= `RST_PORT_DIRECTION;
			dir_b_q <= `RST_PORT_DIRECTION;
		end else if (wr_en) begin
			if (idx == `IDX_PORT_A_DIRECTION) begin
				dir_a_q <= wbyte;
			end
			if (idx == `IDX_PORT_B_DIRECTION) begin
				dir_b_q <= wbyte;
			end
		end
	end

	// per-group trigger, update and optional non-overlap delay
	for (genvar g = 0; g < GROUPS; g++) begin : g_group
		logic [`TRIG_SEL_W-1:0] sel;
		logic [3:0] cur;
		logic [3:0] en;
		logic [3:0] target;
		logic [3:0] rise_q;
		logic [CW-1:0] cnt_q;
		logic nonovl;

		assign sel = trig_sel_q[g*`TRIG_SEL_W +: `TRIG_SEL_W];
		assign grp_trig[g] = compare_match_i[sel];
		assign cur = out_data_q[g*4 +: 4];
		assign en = next_en[g*4 +: 4];
		assign target = (cur & ~en) | (next_pat[g*4 +: 4] & en);
		assign nonovl = mode_q[`MODE_NONOVL_LSB + g];

		// margin counter: the rising half waits until it runs out
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cnt_q <= '0;
				rise_q <= 4'h0;
			end else if (grp_trig[g] && nonovl) begin
				cnt_q <= CW'(MARGIN_CYC);
				rise_q <= target;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - CW'(1);
			end
		end

		// a fresh trigger wins over a pending rising half
		always_comb begin
			grp_upd[g] = 1'b0;
			grp_val[g] = cur;
			if (grp_trig[g]) begin
				grp_upd[g] = 1'b1;
				grp_val[g] = nonovl ? (cur & target) : target;
			end else if (cnt_q == CW'(1)) begin
				grp_upd[g] = 1'b1;
				grp_val[g] = rise_q;
			end
		end
	end

	// output data: bus writes only reach bits not used for pattern output
	always_comb begin
		out_data_d = out_data_q;
		if (wr_en && idx == `IDX_PORT_A_OUTPUT_VALUE) begin
			out_data_d[7:0] = (out_data_q[7:0] & next_en_lo_q) | (wbyte & ~next_en_lo_q);
		end
		if (wr_en && idx == `IDX_PORT_B_OUTPUT_VALUE) begin
			out_data_d[15:8] = (out_data_q[15:8] & next_en_hi_q) | (wbyte & ~next_en_hi_q);
		end
		for (int g = 0; g < GROUPS; g++) begin
			if (grp_upd[g]) begin
				// groups act at the same edge, each on its own nibble
				out_data_d[g*4 +: 4] = (out_data_d[g*4 +: 4] & ~next_en[g*4 +: 4])
					| (grp_val[g] & next_en[g*4 +: 4]);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_data_q <= {`RST_PORT_OUTPUT_VALUE, `RST_PORT_OUTPUT_VALUE};
		end else begin
			out_data_q <= out_data_d;
		end
	end

	// pin stage: one cycle behind the data register, bit 14 never driven
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pattern_out_bit_o <= '0;
		end else begin
			pattern_out_bit_o.value <= out_data_q;
			pattern_out_bit_o.value[`MISSING_BIT_POS] <= 1'b0;
			pattern_out_bit_o.enable <= {dir_b_q, dir_a_q};
			pattern_out_bit_o.enable[`MISSING_BIT_POS] <= 1'b0;
		end
	end

	// answer to the master straight from flops
	assign avl_rsp_o.readdata = rdata_q;
	assign avl_rsp_o.waitrequest = wait_q;

endmodule : timing_pattern_output

`default_nettype wire

//--- tb/timing_pattern_output_monitor.sv
// checker for the pattern pulse unit: bus handshake, readback and pin causes
// assumes one clock domain and the ports of timing_pattern_output only
`timescale 1ns/10ps
`default_nettype none

module timing_pattern_output_monitor #(
	parameter int unsigned CHANNELS = 4,
	parameter int unsigned MARGIN_CYC = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// watched ports
	input wire pattern_pulse_pkg::avl_req_t avl_req_i,
	input wire pattern_pulse_pkg::avl_rsp_t avl_rsp_o,
	input wire logic [CHANNELS-1:0] compare_match_i,
	input wire pattern_pulse_pkg::pattern_pins_t pattern_out_bit_o
);
	logic [7:0] quiet_q;
	logic [15:0] idx;
	logic rack;
	logic mapped;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// decoded read acknowledge and register index
	assign idx = avl_req_i.address[17:2];
	assign rack = avl_req_i.read && !avl_rsp_o.waitrequest;
	assign mapped = (idx >= 16'hffa0 && idx <= 16'hffa7) || idx == 16'hffd1
		|| idx == 16'hffd3 || idx == 16'hffd4 || idx == 16'hffd6;

	// cycles since a trigger or a write; saturates so a long idle never wraps
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) quiet_q <= 8'hff;
		else if (|compare_match_i || (avl_req_i.write && !avl_rsp_o.waitrequest)) quiet_q <= 8'h00;
		else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
	end

	a_bit14_value_off: assert property (!pattern_out_bit_o.value[14])
		else $error("bit 14 value driven");
	a_bit14_enable_off: assert property (!pattern_out_bit_o.enable[14])
		else $error("bit 14 enable driven");
	a_wait_one_cycle: assert property ((avl_req_i.read || avl_req_i.write) && avl_rsp_o.waitrequest |=> !avl_rsp_o.waitrequest)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (!avl_rsp_o.waitrequest |=> avl_rsp_o.waitrequest)
		else $error("ack longer than one cycle");
	a_upper_zero: assert property (rack |-> avl_rsp_o.readdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_unmapped_zero: assert property (rack && !mapped |-> avl_rsp_o.readdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_dir_reads_ones: assert property (rack && (idx == 16'hffd1 || idx == 16'hffd4) |-> avl_rsp_o.readdata[7:0] == 8'hff)
		else $error("direction read not ff");
	a_mode_high_ones: assert property (rack && idx == 16'hffa0 |-> avl_rsp_o.readdata[7:4] == 4'hf)
		else $error("mode high nibble not ones");
	a_pins_need_cause: assert property ($changed(pattern_out_bit_o.value) |-> quiet_q <= 8'(MARGIN_CYC + 3))
		else $error("pin value changed without trigger or write");
	a_enable_needs_write: assert property ($changed(pattern_out_bit_o.enable) |-> quiet_q <= 8'h03)
		else $error("pin enable changed without write");

	// main scenarios reached
	c_read_ack: cover property (rack);
	c_trigger: cover property (|compare_match_i);
	c_pins_move: cover property ($changed(pattern_out_bit_o.value));
endmodule : timing_pattern_output_monitor

bind timing_pattern_output timing_pattern_output_monitor #(.CHANNELS(CHANNELS), .MARGIN_CYC(MARGIN_CYC))
	timing_pattern_output_monitor_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .avl_req_i(avl_req_i),
	.avl_rsp_o(avl_rsp_o), .compare_match_i(compare_match_i), .pattern_out_bit_o(pattern_out_bit_o));

`default_nettype wire

//--- tb/pattern_load_model.sv
// external loads on the pattern pins
// assumes each pin carries a pull-up, so an undriven pin senses high
`timescale 1ns/10ps
`default_nettype none

module pattern_load_model (
	// pin bundle from the unit
	input wire pattern_pulse_pkg::pattern_pins_t pins_i,
	// level the load sees
	output logic [15:0] sensed_o
);
	// a released pin floats to the pull-up, never the last driven level
	assign sensed_o = (pins_i.value & pins_i.enable) | ~pins_i.enable;
endmodule : pattern_load_model

`default_nettype wire

//--- tb/timing_pattern_output_tb_top.sv
// self-checking bench for the pattern pulse unit over avalon-mm
// assumes the package, design, checker and load model are compiled first
`timescale 1ns/10ps
`default_nettype none

module timing_pattern_output_tb_top;
	import pattern_pulse_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	avl_req_t req = '0;
	avl_rsp_t rsp;
	logic [3:0] cm = 4'h0;
	pattern_pins_t pins;
	logic [15:0] sensed;
	int num_errors = 0;
	int checks = 0;
	logic [31:0] rd;

	// 100 mhz clock
	always #5 clk_i = ~clk_i;

	// margin of one cycle keeps the non-overlap wait short
	timing_pattern_output #(.MARGIN_CYC(1)) timing_pattern_output_i (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .avl_req_i(req), .avl_rsp_o(rsp), .compare_match_i(cm),
		.pattern_out_bit_o(pins));
	pattern_load_model pattern_load_model_i (.pins_i(pins), .sensed_o(sensed));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one access; waitrequest sampled as it stood at each edge
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		req.read <= !wr;
		req.write <= wr;
		req.address <= {idx, 2'b00};
		req.writedata <= {24'h000000, wd};
		req.byteenable <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			num_errors++;
			summarize();
		end
		rd = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask : rdchk

	// one-cycle compare pulse, then time for pins and margin to settle
	task automatic pulse(input logic [3:0] m);
		cm <= m;
		@(posedge clk_i);
		cm <= 4'h0;
		repeat (5) @(posedge clk_i);
	endtask : pulse

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize

	// watchdog far beyond the roughly 140 cycles the tests take
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rdchk(16'hffa0, 32'hf0);
		rdchk(16'hffa1, 32'hff);
		rdchk(16'hffa2, 32'h00);
		rdchk(16'hffa3, 32'h00);
		rdchk(16'hffa4, 32'h00);
		rdchk(16'hffa5, 32'h00);
		rdchk(16'hffd1, 32'hff);
		rdchk(16'hffd3, 32'h00);
		rdchk(16'hffb0, 32'h00);
		chk({16'h0, pins.enable}, 32'h0);
		bus(1'b1, 16'hffa0, 8'h05);
		rdchk(16'hffa0, 32'hf5);
		bus(1'b1, 16'hffa0, 8'h00);
		bus(1'b1, 16'hffa1, 8'h1b);
		rdchk(16'hffa1, 32'h1b);
		$display("test reset and readback done");
		// shared trigger on channel 0 for all groups
		bus(1'b1, 16'hffa1, 8'h00);
		bus(1'b1, 16'hffd1, 8'hff);
		bus(1'b1, 16'hffd4, 8'hff);
		bus(1'b1, 16'hffa3, 8'hff);
		bus(1'b1, 16'hffa2, 8'hff);
		bus(1'b1, 16'hffa5, 8'ha5);
		bus(1'b1, 16'hffa4, 8'h5a);
		rdchk(16'hffa5, 32'ha5);
		rdchk(16'hffa4, 32'h5a);
		pulse(4'h1);
		chk({16'h0, sensed}, 32'h5aa5);
		chk({16'h0, pins.enable}, 32'hbfff);
		bus(1'b1, 16'hffd3, 8'h00);
		rdchk(16'hffd3, 32'ha5);
		bus(1'b1, 16'hffa3, 8'h0f);
		bus(1'b1, 16'hffd3, 8'h00);
		rdchk(16'hffd3, 32'h05);
		$display("test shared trigger done");
		// groups 0 and 1 on channels 3 and 2, split next-pattern addresses
		bus(1'b1, 16'hffa3, 8'hff);
		bus(1'b1, 16'hffa1, 8'h1b);
		bus(1'b1, 16'hffa7, 8'h03);
		bus(1'b1, 16'hffa5, 8'hc0);
		rdchk(16'hffa5, 32'hcf);
		rdchk(16'hffa7, 32'hf3);
		pulse(4'h8);
		chk({16'h0, pins.value}, 32'h1a03);
		pulse(4'h4);
		chk({16'h0, pins.value}, 32'h1ac3);
		$display("test split triggers done");
		// non-overlap on group 0
		bus(1'b1, 16'hffa0, 8'h01);
		bus(1'b1, 16'hffa7, 8'h0c);
		pulse(4'h8);
		chk({16'h0, pins.value}, 32'h1acc);
		$display("test non-overlap done");
		summarize();
	end
endmodule : timing_pattern_output_tb_top

`default_nettype wire
